// ---- rtl/sdo_pkg.sv ----
package sdo_pkg;
  // Register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_FORCED = 6'h04;
  localparam logic [5:0] REG_DGAIN = 6'h08;
  localparam logic [5:0] REG_ZMIN = 6'h0C;
  localparam logic [5:0] REG_ZMAX = 6'h10;
  localparam logic [5:0] REG_SCALE = 6'h14;
  localparam logic [5:0] REG_DEMAND = 6'h18;
  localparam logic [5:0] REG_STATUS = 6'h1C;
  localparam logic [5:0] REG_PGAIN = 6'h20;
  // Control fields
  localparam int CTRL_LOOP_ON = 0;
  localparam int CTRL_ENABLE = 1;
  localparam int CTRL_WDOG = 2;
  localparam int CTRL_WIDE = 3;
  localparam int CTRL_KIND_LO = 4;
  localparam int CTRL_KIND_W = 2;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] DGAIN_RST = 16'h0000;
  localparam logic [15:0] PGAIN_RST = 16'h0001;
  localparam logic [15:0] SCALE_RST = 16'h0001;
  localparam logic [15:0] ZONE_RST = 16'h0000;
  // Demand ranges
  localparam int DAC12_MIN = -2048;
  localparam int DAC12_MAX = 2047;
  localparam int DAC16_MIN = -32768;
  localparam int DAC16_MAX = 32767;
  // Axis kind codes for digital demand
  localparam logic [1:0] KIND_ANALOG = 2'h0;
  localparam logic [1:0] KIND_POSITION = 2'h1;
  localparam logic [1:0] KIND_SPEED = 2'h2;
  localparam logic [1:0] KIND_TORQUE = 2'h3;
  // Servo period
  localparam int CLK_MHZ = 250;
  localparam int SERVO_PERIOD_US = 1000;
  localparam int SERVO_CYCLES = SERVO_PERIOD_US * CLK_MHZ;
endpackage

// ---- rtl/sdo_tick.sv ----
`timescale 1ns/1ps
module sdo_tick #(
  parameter int CYCLES = sdo_pkg::SERVO_CYCLES
) (
  input wire logic clock_i,
  input wire logic srst_i,
  output logic tick_o
);
  logic [31:0] count;
  logic [31:0] next_count;

  always_comb begin
    if (count == 32'(CYCLES - 1)) begin
      next_count = 32'h0000_0000;
    end else begin
      next_count = count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      count <= 32'h0000_0000;
    end else begin
      count <= next_count;
    end
  end

  assign tick_o = (count == 32'(CYCLES - 1));
endmodule

// ---- rtl/sdo_sync.sv ----
`timescale 1ns/1ps
module sdo_sync (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // Accept a change only when second and third stages agree
  always_comb begin
    next_level = level_o;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      level_o <= next_level;
    end
  end
endmodule

// ---- rtl/sdo_top.sv ----
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
// Function
// - With the loop on, demand is forced to zero once motion is done and |error| < entry.
// - The clamp releases when |error| > exit or a new move starts.
// - The entry test applies only while the axis has no active motion.
// - Loop off and enable on: the forced value drives the demand.
// - Forced value is stored always, but output is zero without enable.
// - 12-bit demand spans -2048..2047, negative code is positive volts.
// - 16-bit demand spans -32768..32767, positive code positive volts.
// - Readback gives the driven demand: zero without enable or in the clamp with the loop on, else loop or forced value.
// - Digital readback gives position, speed or torque by axis kind.
// - Derivative term is gain times error change, gain resets to 0.
// - Loop output is multiplied by a signed scale, not on position axes.
module sdo_top #(
  parameter int SERVO_CYCLES = sdo_pkg::SERVO_CYCLES
) (
  // System
  input wire logic clock_i,
  input wire logic srst_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Motion state from the profile generator
  input wire logic move_active_i,
  input wire logic signed [31:0] follow_err_i,
  input wire logic signed [31:0] dig_pos_i,
  input wire logic signed [31:0] dig_speed_i,
  input wire logic signed [31:0] dig_torque_i,
  // Watchdog pin
  input wire logic wdog_pin_i,
  // Drive output
  output logic signed [31:0] demand_o,
  output logic servo_tick_o
);
  logic tick;
  logic wdog;
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic signed [31:0] forced;
  logic signed [31:0] next_forced;
  logic signed [15:0] dgain;
  logic signed [15:0] next_dgain;
  logic signed [15:0] pgain;
  logic signed [15:0] next_pgain;
  logic [15:0] zmin;
  logic [15:0] next_zmin;
  logic [15:0] zmax;
  logic [15:0] next_zmax;
  logic signed [15:0] scale;
  logic signed [15:0] next_scale;
  logic signed [31:0] prev_err;
  logic signed [31:0] next_prev_err;
  logic clamp;
  logic next_clamp;
  logic moving_d;
  logic next_moving_d;
  logic signed [31:0] loop_out;
  logic signed [31:0] next_loop_out;
  logic signed [31:0] demand;
  logic signed [31:0] next_demand;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic ack;
  logic next_ack;
  logic [31:0] wmask;
  logic loop_on;
  logic enable;
  logic wide;
  logic [1:0] kind;
  logic [31:0] abs_err;
  logic signed [63:0] raw;
  logic signed [31:0] loop_sat;
  logic signed [31:0] forced_sat;

  sdo_tick #(
    .CYCLES(SERVO_CYCLES)
  ) u_tick (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tick_o(tick)
  );

  sdo_sync u_wdog (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pin_i(wdog_pin_i),
    .level_o(wdog)
  );

  assign loop_on = ctrl[sdo_pkg::CTRL_LOOP_ON];
  assign enable = ctrl[sdo_pkg::CTRL_ENABLE] & ctrl[sdo_pkg::CTRL_WDOG]
                  & wdog;
  assign wide = ctrl[sdo_pkg::CTRL_WIDE];
  assign kind = ctrl[sdo_pkg::CTRL_KIND_LO +: sdo_pkg::CTRL_KIND_W];
  assign abs_err = follow_err_i[31] ? 32'(-follow_err_i) : follow_err_i;

  function automatic logic signed [31:0] sat(input logic signed [63:0] v,
                                             input logic w);
    logic signed [63:0] lo;
    logic signed [63:0] hi;
    lo = w ? 64'(sdo_pkg::DAC16_MIN) : 64'(sdo_pkg::DAC12_MIN);
    hi = w ? 64'(sdo_pkg::DAC16_MAX) : 64'(sdo_pkg::DAC12_MAX);
    if (v < lo) begin
      sat = 32'(lo);
    end else if (v > hi) begin
      sat = 32'(hi);
    end else begin
      sat = 32'(v);
    end
  endfunction

  // Byte-enable write mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
    end
  end

  // Register bus: one wait cycle, then answer
  always_comb begin
    next_ctrl = ctrl;
    next_forced = forced;
    next_dgain = dgain;
    next_pgain = pgain;
    next_zmin = zmin;
    next_zmax = zmax;
    next_scale = scale;
    next_rdata = rdata;
    next_ack = 1'b0;
    if (avs_read_i || avs_write_i) begin
      next_ack = !ack;
      // Write lands on the edge where waitrequest is seen low
      if (avs_write_i && ack) begin
        case (avs_address_i)
          sdo_pkg::REG_CTRL:
            next_ctrl = (ctrl & ~wmask) | (avs_writedata_i & wmask);
          sdo_pkg::REG_FORCED: begin
            // Held regardless of enable
            next_forced = (forced & ~wmask) | (avs_writedata_i & wmask);
          end
          sdo_pkg::REG_DGAIN:
            next_dgain = 16'((dgain & ~wmask[15:0])
                             | (avs_writedata_i[15:0] & wmask[15:0]));
          sdo_pkg::REG_PGAIN:
            next_pgain = 16'((pgain & ~wmask[15:0])
                             | (avs_writedata_i[15:0] & wmask[15:0]));
          sdo_pkg::REG_ZMIN:
            next_zmin = (zmin & ~wmask[15:0])
                        | (avs_writedata_i[15:0] & wmask[15:0]);
          sdo_pkg::REG_ZMAX:
            next_zmax = (zmax & ~wmask[15:0])
                        | (avs_writedata_i[15:0] & wmask[15:0]);
          sdo_pkg::REG_SCALE:
            next_scale = 16'((scale & ~wmask[15:0])
                             | (avs_writedata_i[15:0] & wmask[15:0]));
          default: begin
          end
        endcase
      end else if (avs_read_i && !ack) begin
        case (avs_address_i)
          sdo_pkg::REG_CTRL: next_rdata = ctrl;
          sdo_pkg::REG_FORCED: next_rdata = forced;
          sdo_pkg::REG_DGAIN: next_rdata = {{16{dgain[15]}}, dgain};
          sdo_pkg::REG_PGAIN: next_rdata = {{16{pgain[15]}}, pgain};
          sdo_pkg::REG_ZMIN: next_rdata = {16'h0000, zmin};
          sdo_pkg::REG_ZMAX: next_rdata = {16'h0000, zmax};
          sdo_pkg::REG_SCALE: next_rdata = {{16{scale[15]}}, scale};
          sdo_pkg::REG_DEMAND: begin
            // Digital axes report the quantity set by the kind code
            case (kind)
              sdo_pkg::KIND_POSITION: next_rdata = dig_pos_i;
              sdo_pkg::KIND_SPEED: next_rdata = dig_speed_i;
              sdo_pkg::KIND_TORQUE: next_rdata = dig_torque_i;
              default: next_rdata = demand;
            endcase
          end
          sdo_pkg::REG_STATUS:
            next_rdata = {28'h0000000, wdog, moving_d, clamp, enable};
          default: next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Servo algorithm, evaluated once per servo period
  always_comb begin
    next_prev_err = prev_err;
    next_clamp = clamp;
    next_moving_d = moving_d;
    next_loop_out = loop_out;
    next_demand = demand;
    raw = 64'(pgain) * 64'(follow_err_i)
          + 64'(dgain) * 64'(follow_err_i - prev_err);
    // Scale skipped on position axes since drive closes its own loop
    if (kind != sdo_pkg::KIND_POSITION) begin
      raw = raw * 64'(scale);
    end
    loop_sat = sat(raw, wide);
    forced_sat = sat(64'(forced), wide);
    if (tick) begin
      next_prev_err = follow_err_i;
      next_moving_d = move_active_i;
      if (clamp) begin
        if (abs_err > 32'(zmax) || (move_active_i && !moving_d)) begin
          next_clamp = 1'b0;
        end
      end else if (!move_active_i && abs_err < 32'(zmin)) begin
        next_clamp = loop_on;
      end
      next_loop_out = loop_sat;
      if (!enable) begin
        next_demand = 32'h0000_0000;
      end else if (!loop_on) begin
        next_demand = forced_sat;
      end else if (next_clamp) begin
        next_demand = 32'h0000_0000;
      end else begin
        next_demand = loop_sat;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl <= sdo_pkg::CTRL_RST;
      forced <= 32'h0000_0000;
      dgain <= sdo_pkg::DGAIN_RST;
      pgain <= sdo_pkg::PGAIN_RST;
      zmin <= sdo_pkg::ZONE_RST;
      zmax <= sdo_pkg::ZONE_RST;
      scale <= sdo_pkg::SCALE_RST;
      prev_err <= 32'h0000_0000;
      clamp <= 1'b0;
      moving_d <= 1'b0;
      loop_out <= 32'h0000_0000;
      demand <= 32'h0000_0000;
      rdata <= 32'h0000_0000;
      ack <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      forced <= next_forced;
      dgain <= next_dgain;
      pgain <= next_pgain;
      zmin <= next_zmin;
      zmax <= next_zmax;
      scale <= next_scale;
      prev_err <= next_prev_err;
      clamp <= next_clamp;
      moving_d <= next_moving_d;
      loop_out <= next_loop_out;
      demand <= next_demand;
      rdata <= next_rdata;
      ack <= next_ack;
    end
  end

  assign avs_readdata_o = rdata;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
  assign demand_o = demand;
  assign servo_tick_o = tick;
endmodule

// ---- sim/sdo_chk.sv ----
`timescale 1ns/1ps
module sdo_chk #(
  parameter int SERVO_CYCLES = 8
) (
  // System
  input wire logic clock_i,
  input wire logic srst_i,
  // Bus
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Drive
  input wire logic signed [31:0] demand_o,
  input wire logic servo_tick_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic req;
  logic seen;
  logic next_seen;
  int gap;
  int next_gap;
  assign req = avs_read_i | avs_write_i;
  always_comb begin
    next_gap = servo_tick_o ? 0 : gap + 1;
    next_seen = seen | servo_tick_o;
  end
  always_ff @(posedge clock_i) begin
    gap <= srst_i ? 0 : next_gap;
    seen <= srst_i ? 1'h0 : next_seen;
  end
  property p_wait_first;
    $rose(req) |-> avs_waitrequest_o;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait");
  property p_wait_one;
    avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("long wait");
  property p_idle;
    !req |-> !avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle wait");
  property p_unmapped;
    avs_read_i && !avs_waitrequest_o && avs_address_i > 6'h20
      |-> avs_readdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_hold;
    !$past(servo_tick_o) |-> $stable(demand_o);
  endproperty
  a_hold: assert property (p_hold) else $error("demand moved");
  property p_rst_zero;
    $past(srst_i) |-> demand_o == 32'h0;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("demand after reset");
  property p_range;
    demand_o >= sdo_pkg::DAC16_MIN && demand_o <= sdo_pkg::DAC16_MAX;
  endproperty
  a_range: assert property (p_range) else $error("demand range");
  property p_gap;
    servo_tick_o && seen |-> gap == SERVO_CYCLES - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("tick period");
  c_tick: cover property (servo_tick_o);
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_demand: cover property ($changed(demand_o));
endmodule
bind sdo_top sdo_chk #(.SERVO_CYCLES(SERVO_CYCLES)) u_sdo_chk (
  .clock_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .demand_o, .servo_tick_o);

// ---- sim/sdo_drive_model.sv ----
`timescale 1ns/1ps
module sdo_drive_model (
  // System
  input wire logic clock_i,
  input wire logic srst_i,
  // Demand from the controller
  input wire logic tick_i,
  input wire logic signed [31:0] demand_i,
  output logic signed [31:0] applied_o
);
  logic tick_q;
  // Drive takes the demand once it settles after a tick
  always_ff @(posedge clock_i) begin
    tick_q <= tick_i;
    if (srst_i)
      applied_o <= 32'sh0;
    else if (tick_q)
      applied_o <= demand_i;
  end
endmodule

// ---- sim/sdo_top_tb.sv ----
`timescale 1ns/1ps
module sdo_top_tb;
  logic clock_i = 1'h0;
  logic srst_i = 1'h1;
  logic [5:0] avs_address_i = 6'h0;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic move_active_i = 1'h0;
  logic signed [31:0] follow_err_i = 32'sh0;
  logic signed [31:0] dig_pos_i = 32'sh11;
  logic signed [31:0] dig_speed_i = 32'sh22;
  logic signed [31:0] dig_torque_i = 32'sh33;
  logic wdog_pin_i = 1'h1;
  logic signed [31:0] demand_o;
  logic servo_tick_o;
  logic signed [31:0] applied;
  logic [31:0] rd;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  always #2 clock_i = ~clock_i;
  sdo_top #(.SERVO_CYCLES(8)) u_sdo_top (.clock_i, .srst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .move_active_i, .follow_err_i, .dig_pos_i, .dig_speed_i,
    .dig_torque_i, .wdog_pin_i, .demand_o, .servo_tick_o);
  sdo_drive_model u_sdo_drive_model (.clock_i, .srst_i,
    .tick_i(servo_tick_o), .demand_i(demand_o), .applied_o(applied));
  task end_sim;
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_sim;
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do @(posedge clock_i); while (avs_waitrequest_o);
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask
  task dem(input int n, input logic [31:0] e);
    repeat (n) begin
      do @(negedge clock_i); while (!servo_tick_o);
      repeat (2) @(posedge clock_i);
    end
    @(negedge clock_i);
    chk("demand", demand_o, e);
    chk("drive", applied, e);
  endtask
  task setin(input logic mv, input logic [31:0] e);
    @(posedge clock_i);
    move_active_i <= mv;
    follow_err_i <= e;
  endtask
  task t_reset;
    bus(0, sdo_pkg::REG_DGAIN, 0);
    chk("dgain", rd, 32'h0);
    bus(0, sdo_pkg::REG_PGAIN, 0);
    chk("pgain", rd, 32'h1);
    bus(0, sdo_pkg::REG_SCALE, 0);
    chk("scale", rd, 32'h1);
    avs_byteenable_i <= 4'h1;
    bus(1, sdo_pkg::REG_SCALE, 32'hFFFF_FF05);
    avs_byteenable_i <= 4'hF;
    bus(0, sdo_pkg::REG_SCALE, 0);
    chk("scale lane", rd, 32'h5);
    bus(0, 6'h24, 0);
    chk("unmapped", rd, 32'h0);
  endtask
  task t_forced;
    bus(1, sdo_pkg::REG_FORCED, 32'h64);
    dem(2, 32'h0);
    bus(0, sdo_pkg::REG_FORCED, 0);
    chk("forced", rd, 32'h64);
    bus(1, sdo_pkg::REG_CTRL, 32'h6);
    dem(2, 32'h64);
    bus(0, sdo_pkg::REG_DEMAND, 0);
    chk("readback", rd, 32'h64);
    wdog_pin_i <= 1'h0;
    dem(2, 32'h0);
    wdog_pin_i <= 1'h1;
    bus(1, sdo_pkg::REG_FORCED, 32'hFFFF_EC78);
    dem(2, 32'hFFFF_F800);
    bus(1, sdo_pkg::REG_CTRL, 32'hE);
    dem(2, 32'hFFFF_EC78);
    bus(1, sdo_pkg::REG_FORCED, 32'h9C40);
    dem(2, 32'h7FFF);
  endtask
  task t_loop;
    bus(1, sdo_pkg::REG_CTRL, 32'h7);
    bus(1, sdo_pkg::REG_DGAIN, 32'h2);
    bus(1, sdo_pkg::REG_SCALE, 32'h3);
    setin(1, 32'hA);
    dem(2, 32'h1E);
    setin(1, 32'hE);
    dem(1, 32'h42);
    bus(0, sdo_pkg::REG_DEMAND, 0);
    chk("readback", rd, 32'h42);
    dem(1, 32'h2A);
    bus(1, sdo_pkg::REG_CTRL, 32'h17);
    dem(2, 32'hE);
  endtask
  task t_zone;
    bus(1, sdo_pkg::REG_CTRL, 32'h7);
    bus(1, sdo_pkg::REG_DGAIN, 32'h0);
    bus(1, sdo_pkg::REG_SCALE, 32'h1);
    bus(1, sdo_pkg::REG_ZMIN, 32'h5);
    bus(1, sdo_pkg::REG_ZMAX, 32'hA);
    setin(1, 32'h3);
    dem(2, 32'h3);
    setin(0, 32'hFFFF_FFFD);
    dem(2, 32'h0);
    setin(0, 32'h8);
    dem(2, 32'h0);
    setin(0, 32'hC);
    dem(2, 32'hC);
    setin(0, 32'h2);
    dem(2, 32'h0);
    setin(1, 32'h2);
    dem(2, 32'h2);
  endtask
  task t_dig;
    for (int k = 1; k < 4; k++) begin
      bus(1, sdo_pkg::REG_CTRL, 32'h7 | (k << 4));
      bus(0, sdo_pkg::REG_DEMAND, 0);
      chk("digital", rd, 32'h11 * k);
    end
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    srst_i <= 1'h0;
    t_reset;
    t_forced;
    t_loop;
    t_zone;
    t_dig;
    end_sim;
  end
endmodule
